// File: ebd_pkg.sv
// shared constants and state type of the external bus dram controller
// assumes one system clock; all constants used by package reference only
package ebd_pkg;

  // =====================================================================
  // address decode
  localparam logic [7:0] DRAM_SPACE = 8'h01;
  localparam int CS_FIELD_LSB = 26;
  localparam logic [1:0] MUX_IO_SPACE = 2'h3;
  localparam int MUX_WIDTH_BIT = 14;
  localparam int ROW_SHIFT_BASE = 9;

  // =====================================================================
  // timing counts
  localparam logic [1:0] MUX_ADDR_CYCLES = 2'h3;
  localparam logic [1:0] EXT_WAIT_MIN = 2'h2;
  localparam int PRESC_W = 12;
  localparam logic [11:0] CLK_DIV_MASK [0:7] = '{12'h000, 12'h001, 12'h007,
    12'h01f, 12'h07f, 12'h1ff, 12'h7ff, 12'hfff};

  // =====================================================================
  // reset values
  localparam logic [7:0] REFRESH_COUNTER_RESET = 8'h00;
  localparam logic [11:0] PRESC_RESET = 12'h000;

  // =====================================================================
  // bus cycle states
  typedef enum logic [4:0] {
    ST_IDLE, ST_HEAD, ST_ADDR, ST_T1, ST_TW, ST_T2, ST_TAIL,
    ST_TP, ST_TPW, ST_TR, ST_TRW, ST_TC1, ST_TCW, ST_TC2,
    ST_RF_PRE, ST_RF_CAS, ST_RF_RAS, ST_SELF
  } ebd_state_e;

endpackage : ebd_pkg

// File: ebd_addr_mux.sv
// row and column address forms of a dram space address
// assumes the row shift code is stable while an access runs
`timescale 1ns/1ps
module ebd_addr_mux (
  input wire logic [23:0] addr,
  input wire logic [1:0] row_shift,
  output logic [21:0] row_addr,
  output logic [21:0] col_addr
);

  logic [21:0] low_mask;

  // =====================================================================
  // multiplexer
  // upper bits slide down onto the low pins by 9..12 places
  // pins above the shifted field keep their own address bits
  always_comb begin
    low_mask = 22'h3fffff >> (ebd_pkg::ROW_SHIFT_BASE - 2 + int'(row_shift));
    row_addr = (addr[21:0] & ~low_mask)
      | (22'(addr >> (ebd_pkg::ROW_SHIFT_BASE + int'(row_shift))) & low_mask);
    col_addr = addr[21:0];
  end

endmodule : ebd_addr_mux

// File: ebd_refresh_timer.sv
// refresh interval timer: prescaler, 8-bit up counter, compare and flag
// assumes register writes arrive as one-cycle strobes from the owner
`timescale 1ns/1ps
module ebd_refresh_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [2:0] counter_clock_select,
  input wire logic [7:0] refresh_compare_value,
  input wire logic cnt_wr,
  input wire logic [7:0] cnt_wdata,
  input wire logic match_flag_clr,
  input wire logic match_interrupt_enable,
  output logic [7:0] refresh_counter,
  output logic match_flag,
  output logic match_irq,
  output logic match_pulse
);

  typedef struct packed {
    logic [11:0] presc;
    logic [7:0] cnt;
    logic flag;
    logic irq;
    logic match;
  } ebd_tmr_s;

  ebd_tmr_s s, n;
  logic tick;
  logic [7:0] inc;

  // =====================================================================
  // next state
  // a write to the counter beats a tick in the same cycle
  always_comb begin
    n = s;
    n.match = 1'b0;
    inc = s.cnt + 8'h01;
    tick = (counter_clock_select != 3'h0) &&
      ((s.presc & ebd_pkg::CLK_DIV_MASK[counter_clock_select]) ==
      ebd_pkg::CLK_DIV_MASK[counter_clock_select]);
    n.presc = (counter_clock_select == 3'h0) ? ebd_pkg::PRESC_RESET
      : s.presc + 12'h001;
    if (cnt_wr) begin
      n.cnt = cnt_wdata;
    end else if (tick) begin
      if (inc == refresh_compare_value) begin
        n.cnt = ebd_pkg::REFRESH_COUNTER_RESET;
        n.match = 1'b1;
      end else begin
        n.cnt = inc;
      end
    end
    // set wins over a clear in the same cycle
    if (match_flag_clr) begin
      n.flag = 1'b0;
    end
    if (n.match) begin
      n.flag = 1'b1;
    end
    n.irq = n.flag & match_interrupt_enable;
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign refresh_counter = s.cnt;
  assign match_flag = s.flag;
  assign match_irq = s.irq;
  assign match_pulse = s.match;

endmodule : ebd_refresh_timer

// File: ebd_bus_ctrl.sv
// bus state controller: ordinary, mux i/o and dram cycles plus refresh
// assumes one request at a time from the internal master, held until DONE
`timescale 1ns/1ps

// Contract
// - programmed ordinary waits also sample the external wait and extend.
// - external wait sampled at the edge where the last wait leaves to T2.
// - chip-select extension adds a lead and a tail cycle, strobes off.
// - write data keeps driving through the tail cycle.
// - upper address byte 01 selects the dram space protocol.
// - dram row and column share the address pins, shift 9 to 12.
// - shift code 0..3 means 9..12 bits; column goes out unshifted.
// - dram cycle built from precharge, row, column and fetch cycles.
// - one column strobe per active byte lane.
// - dma single transfers also drive read and write strobes in column.
// - precharge and row delay common; separate read and write waits.
// - dram external wait honoured only with 2 or 3 software waits.
// - burst enable gives fast page accesses to the same row.
// - with burst enable and row hold, row strobe stays low across other accesses.
// - counter match with refresh mode 0 runs a refresh before row.
// - refresh row strobe width follows the two-bit width field.
// - self refresh asserts column and row strobes and holds them.
// - bus release in self refresh keeps only row, column, direction.
// - mux i/o enable puts address and data of space 3 on D15-D0.
// - address bit 14 picks 8 or 16 bit mux i/o width.
// - mux i/o begins with three address cycles, then ordinary cycle.
// - clock select 0 stops, others divide by 2 up to 4096.
// - one pending refresh request; a new match replaces the old.
// - match clears the counter, sets the flag, raises enabled interrupt.
// - self refresh waits for the access end; timer refresh ignored in it.
module ebd_bus_ctrl (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic REQ_VALID,
  input wire logic [31:0] REQ_ADDR,
  input wire logic REQ_WRITE,
  input wire logic [3:0] REQ_BE,
  input wire logic [31:0] REQ_WDATA,
  input wire logic REQ_DMA_SINGLE,
  output logic REQ_BUSY,
  output logic REQ_DONE,
  output logic [31:0] REQ_RDATA,
  input wire logic [1:0] ORD_WAITS,
  input wire logic [3:0] SELECT_EXTEND_FIELD,
  input wire logic [1:0] ROW_SHIFT,
  input wire logic PRECHARGE_WAIT,
  input wire logic ROW_TO_COLUMN_DELAY,
  input wire logic [1:0] DRAM_WRITE_WAIT,
  input wire logic [1:0] DRAM_READ_WAIT,
  input wire logic BURST_ENABLE_BIT,
  input wire logic ROW_HOLD_MODE,
  input wire logic [1:0] REFRESH_ROW_WIDTH,
  input wire logic MUX_IO_ENABLE,
  input wire logic [2:0] COUNTER_CLOCK_SELECT,
  input wire logic REFRESH_ENABLE_BIT,
  input wire logic REFRESH_MODE_SELECT,
  input wire logic [7:0] REFRESH_COMPARE_VALUE,
  input wire logic REFRESH_COUNTER_WR,
  input wire logic [7:0] REFRESH_COUNTER_WDATA,
  input wire logic MATCH_FLAG_CLR,
  input wire logic MATCH_INTERRUPT_ENABLE,
  output logic [7:0] REFRESH_COUNTER,
  output logic MATCH_FLAG,
  output logic MATCH_IRQ,
  input wire logic EXT_GRANT,
  output logic BUS_RELEASED,
  input wire logic WAIT_N,
  output logic [21:0] ADDR_OUT,
  output logic [3:0] CHIP_SELECT_N,
  output logic READ_STROBE_N,
  output logic [3:0] WRITE_STROBE_LANE_N,
  output logic ROW_STROBE_N,
  output logic [3:0] COLUMN_STROBE_LANE_N,
  output logic READ_WRITE_DIRECTION,
  output logic ADDRESS_PHASE_STROBE_N,
  output logic [31:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic [31:0] DATA_IN
);

  typedef struct packed {
    ebd_pkg::ebd_state_e state;
    logic [1:0] cnt;
    logic [31:0] addr;
    logic wr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic dma;
    logic ext;
    logic row_open;
    logic [21:0] open_row;
    logic ref_pend;
    logic busy;
    logic done;
    logic [31:0] rdata;
    logic released;
    logic [21:0] addr_out;
    logic [3:0] cs_n;
    logic rd_n;
    logic [3:0] wr_n;
    logic ras_n;
    logic [3:0] cas_n;
    logic read_write_direction;
    logic ah_n;
    logic [31:0] d_out;
    logic d_oe;
  } ebd_ctl_s;

  ebd_ctl_s s, n;
  logic [21:0] req_row, cur_row, cur_col;
  logic match_pulse, match_cbr, self_req, req_dram, page_hit, keep_open;
  logic [1:0] req_cs, dram_wait;

  // decode of the chip-select index, used for the live and held address
  function automatic logic [1:0] cs_index(input logic [31:0] a);
    cs_index = a[ebd_pkg::CS_FIELD_LSB +: 2];
  endfunction : cs_index

  // =====================================================================
  // refresh timer and address forms
  ebd_refresh_timer u_timer (
    .clk(CLOCK),
    .rst_n(RESETN),
    .ce(CE),
    .counter_clock_select(COUNTER_CLOCK_SELECT),
    .refresh_compare_value(REFRESH_COMPARE_VALUE),
    .cnt_wr(REFRESH_COUNTER_WR),
    .cnt_wdata(REFRESH_COUNTER_WDATA),
    .match_flag_clr(MATCH_FLAG_CLR),
    .match_interrupt_enable(MATCH_INTERRUPT_ENABLE),
    .refresh_counter(REFRESH_COUNTER),
    .match_flag(MATCH_FLAG),
    .match_irq(MATCH_IRQ),
    .match_pulse(match_pulse)
  );

  ebd_addr_mux u_req_mux (
    .addr(REQ_ADDR[23:0]),
    .row_shift(ROW_SHIFT),
    .row_addr(req_row),
    .col_addr()
  );

  ebd_addr_mux u_cur_mux (
    .addr(s.addr[23:0]),
    .row_shift(ROW_SHIFT),
    .row_addr(cur_row),
    .col_addr(cur_col)
  );

  // =====================================================================
  // sequencer
  // the whole cycle is one state machine so refresh can never cut an access
  always_comb begin
    n = s;
    n.done = 1'b0;
    req_cs = cs_index(REQ_ADDR);
    req_dram = REQ_ADDR[31:24] == ebd_pkg::DRAM_SPACE;
    page_hit = s.row_open && req_dram && (req_row == s.open_row);
    self_req = REFRESH_ENABLE_BIT & REFRESH_MODE_SELECT;
    match_cbr = match_pulse & REFRESH_ENABLE_BIT & ~REFRESH_MODE_SELECT
      & (s.state != ebd_pkg::ST_SELF);
    n.ref_pend = s.ref_pend | match_cbr;
    dram_wait = s.wr ? DRAM_WRITE_WAIT : DRAM_READ_WAIT;
    keep_open = BURST_ENABLE_BIT & (ROW_HOLD_MODE | (REQ_VALID & page_hit));
    unique case (s.state)
      ebd_pkg::ST_IDLE: begin
        if (s.row_open && !(BURST_ENABLE_BIT && ROW_HOLD_MODE) && !page_hit) begin
          n.row_open = 1'b0;
        end
        // self refresh is only entered from idle, after any access ends
        if (self_req || s.ref_pend) begin
          n.row_open = 1'b0;
          n.state = ebd_pkg::ST_RF_PRE;
        end else if (REQ_VALID && !EXT_GRANT) begin
          n.addr = REQ_ADDR;
          n.wr = REQ_WRITE;
          n.be = REQ_BE;
          n.wdata = REQ_WDATA;
          n.dma = REQ_DMA_SINGLE;
          n.ext = 1'b0;
          if (req_dram) begin
            n.state = page_hit ? ebd_pkg::ST_TC1 : ebd_pkg::ST_TP;
          end else if (MUX_IO_ENABLE && req_cs == ebd_pkg::MUX_IO_SPACE) begin
            n.cnt = ebd_pkg::MUX_ADDR_CYCLES - 2'h1;
            n.state = ebd_pkg::ST_ADDR;
          end else if (SELECT_EXTEND_FIELD[req_cs]) begin
            n.ext = 1'b1;
            n.state = ebd_pkg::ST_HEAD;
          end else begin
            n.state = ebd_pkg::ST_T1;
          end
        end
      end
      ebd_pkg::ST_HEAD: n.state = ebd_pkg::ST_T1;
      ebd_pkg::ST_ADDR: begin
        if (s.cnt == 2'h0) begin
          n.state = ebd_pkg::ST_T1;
        end else begin
          n.cnt = s.cnt - 2'h1;
        end
      end
      ebd_pkg::ST_T1: begin
        n.cnt = ORD_WAITS;
        n.state = (ORD_WAITS != 2'h0) ? ebd_pkg::ST_TW : ebd_pkg::ST_T2;
      end
      ebd_pkg::ST_TW: begin
        // outputs are not recomputed from new inputs while waiting
        if (s.cnt > 2'h1) begin
          n.cnt = s.cnt - 2'h1;
        end else if (WAIT_N) begin
          n.state = ebd_pkg::ST_T2;
        end
      end
      ebd_pkg::ST_T2: begin
        n.rdata = DATA_IN;
        n.done = 1'b1;
        n.state = s.ext ? ebd_pkg::ST_TAIL : ebd_pkg::ST_IDLE;
      end
      ebd_pkg::ST_TAIL: n.state = ebd_pkg::ST_IDLE;
      ebd_pkg::ST_TP: begin
        n.row_open = 1'b0;
        n.state = PRECHARGE_WAIT ? ebd_pkg::ST_TPW : ebd_pkg::ST_TR;
      end
      ebd_pkg::ST_TPW: n.state = ebd_pkg::ST_TR;
      ebd_pkg::ST_TR: begin
        n.row_open = 1'b1;
        n.open_row = cur_row;
        n.state = ROW_TO_COLUMN_DELAY ? ebd_pkg::ST_TRW : ebd_pkg::ST_TC1;
      end
      ebd_pkg::ST_TRW: n.state = ebd_pkg::ST_TC1;
      ebd_pkg::ST_TC1: begin
        n.cnt = dram_wait;
        n.state = (dram_wait != 2'h0) ? ebd_pkg::ST_TCW : ebd_pkg::ST_TC2;
      end
      ebd_pkg::ST_TCW: begin
        if (s.cnt > 2'h1) begin
          n.cnt = s.cnt - 2'h1;
        end else if (WAIT_N || dram_wait < ebd_pkg::EXT_WAIT_MIN) begin
          n.state = ebd_pkg::ST_TC2;
        end
      end
      ebd_pkg::ST_TC2: begin
        n.rdata = DATA_IN;
        n.done = 1'b1;
        n.row_open = keep_open;
        n.state = ebd_pkg::ST_IDLE;
      end
      ebd_pkg::ST_RF_PRE: n.state = ebd_pkg::ST_RF_CAS;
      ebd_pkg::ST_RF_CAS: begin
        n.cnt = REFRESH_ROW_WIDTH;
        n.ref_pend = match_cbr;
        n.state = self_req ? ebd_pkg::ST_SELF : ebd_pkg::ST_RF_RAS;
      end
      ebd_pkg::ST_RF_RAS: begin
        if (s.cnt == 2'h0) begin
          n.state = ebd_pkg::ST_IDLE;
        end else begin
          n.cnt = s.cnt - 2'h1;
        end
      end
      ebd_pkg::ST_SELF: begin
        if (!self_req) begin
          n.state = ebd_pkg::ST_IDLE;
        end
      end
    endcase

    // pin levels for the state being entered
    n.busy = n.state != ebd_pkg::ST_IDLE;
    n.released = EXT_GRANT &&
      (n.state == ebd_pkg::ST_IDLE || n.state == ebd_pkg::ST_SELF);
    n.cs_n = 4'hf;
    n.rd_n = 1'b1;
    n.wr_n = 4'hf;
    n.ras_n = ~n.row_open;
    n.cas_n = 4'hf;
    n.read_write_direction = 1'b1;
    n.ah_n = 1'b1;
    n.d_oe = 1'b0;
    n.d_out = s.wdata;
    unique case (n.state)
      ebd_pkg::ST_HEAD, ebd_pkg::ST_TAIL: begin
        n.cs_n[cs_index(n.addr)] = 1'b0;
        n.addr_out = n.addr[21:0];
        n.d_out = n.wdata;
        n.d_oe = n.wr && n.state == ebd_pkg::ST_TAIL;
      end
      ebd_pkg::ST_ADDR: begin
        n.cs_n[cs_index(n.addr)] = 1'b0;
        n.ah_n = 1'b0;
        n.addr_out = n.addr[21:0];
        n.d_out = n.addr[ebd_pkg::MUX_WIDTH_BIT] ? {16'h0000, n.addr[15:0]}
          : {24'h000000, n.addr[7:0]};
        n.d_oe = 1'b1;
      end
      ebd_pkg::ST_T1, ebd_pkg::ST_TW, ebd_pkg::ST_T2: begin
        n.cs_n[cs_index(n.addr)] = 1'b0;
        n.addr_out = n.addr[21:0];
        n.rd_n = n.wr;
        n.wr_n = n.wr ? ~n.be : 4'hf;
        n.d_out = n.wdata;
        n.d_oe = n.wr;
      end
      ebd_pkg::ST_TP, ebd_pkg::ST_TPW, ebd_pkg::ST_RF_PRE: n.ras_n = 1'b1;
      ebd_pkg::ST_TR, ebd_pkg::ST_TRW: begin
        n.ras_n = 1'b0;
        n.addr_out = cur_row;
        n.read_write_direction = ~n.wr;
        n.d_oe = n.wr;
      end
      ebd_pkg::ST_TC1, ebd_pkg::ST_TCW, ebd_pkg::ST_TC2: begin
        n.ras_n = 1'b0;
        n.cas_n = ~n.be;
        n.addr_out = (s.state == ebd_pkg::ST_IDLE) ? n.addr[21:0] : cur_col;
        n.read_write_direction = ~n.wr;
        n.d_oe = n.wr;
        if (n.dma) begin
          n.rd_n = n.wr;
          n.wr_n = n.wr ? ~n.be : 4'hf;
        end
      end
      ebd_pkg::ST_RF_CAS: n.cas_n = 4'h0;
      ebd_pkg::ST_RF_RAS, ebd_pkg::ST_SELF: begin
        n.cas_n = 4'h0;
        n.ras_n = 1'b0;
      end
      ebd_pkg::ST_IDLE: n.d_oe = 1'b0;
    endcase
  end

  // =====================================================================
  // state register
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      s <= '0;
      s.state <= ebd_pkg::ST_IDLE;
      s.cs_n <= 4'hf;
      s.rd_n <= 1'b1;
      s.wr_n <= 4'hf;
      s.ras_n <= 1'b1;
      s.cas_n <= 4'hf;
      s.read_write_direction <= 1'b1;
      s.ah_n <= 1'b1;
    end else if (CE) begin
      s <= n;
    end
  end

  // =====================================================================
  // outputs straight from the state register
  assign REQ_BUSY = s.busy;
  assign REQ_DONE = s.done;
  assign REQ_RDATA = s.rdata;
  assign BUS_RELEASED = s.released;
  assign ADDR_OUT = s.addr_out;
  assign CHIP_SELECT_N = s.cs_n;
  assign READ_STROBE_N = s.rd_n;
  assign WRITE_STROBE_LANE_N = s.wr_n;
  assign ROW_STROBE_N = s.ras_n;
  assign COLUMN_STROBE_LANE_N = s.cas_n;
  assign READ_WRITE_DIRECTION = s.read_write_direction;
  assign ADDRESS_PHASE_STROBE_N = s.ah_n;
  assign DATA_OUT = s.d_out;
  assign DATA_OE = s.d_oe;

endmodule : ebd_bus_ctrl

// File: ebd_bus_ctrl_sva.sv
// checker of the bus state controller ports
// assumes one clock domain, reset active low
`timescale 1ns/1ps
module ebd_bus_ctrl_sva (
  input wire logic CLOCK,
  RESETN,
  REQ_VALID,
  REQ_BUSY,
  REQ_DONE,
  PRECHARGE_WAIT,
  BURST_ENABLE_BIT,
  REFRESH_ENABLE_BIT,
  REFRESH_MODE_SELECT,
  REFRESH_COUNTER_WR,
  MATCH_FLAG,
  BUS_RELEASED,
  READ_STROBE_N,
  ROW_STROBE_N,
  ADDRESS_PHASE_STROBE_N,
  DATA_OE,
  input wire logic [3:0] REQ_BE,
  CHIP_SELECT_N,
  WRITE_STROBE_LANE_N,
  COLUMN_STROBE_LANE_N,
  input wire logic [2:0] COUNTER_CLOCK_SELECT,
  input wire logic [7:0] REFRESH_COUNTER,
  input wire logic [31:0] REQ_ADDR
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  // ===
  // strobe framing
  // a read outside any chip select hits a deselected part
  rd_inside_cs_a: assert property (
    !READ_STROBE_N && &COLUMN_STROBE_LANE_N |-> !(&CHIP_SELECT_N))
    else $error("no cs on read");
  dram_no_cs_a: assert property (
    REQ_BUSY && REQ_VALID && REQ_ADDR[31:24] == 8'h01 |-> &CHIP_SELECT_N)
    else $error("cs in dram");
  dram_pre_row_a: assert property (
    $rose(REQ_BUSY) && REQ_VALID && REQ_ADDR[31:24] == 8'h01 && !PRECHARGE_WAIT
      && !BURST_ENABLE_BIT && !REFRESH_ENABLE_BIT |-> ROW_STROBE_N ##1 !ROW_STROBE_N)
    else $error("row order");
  cas_lanes_a: assert property (
    REQ_VALID && !REFRESH_ENABLE_BIT && !(&COLUMN_STROBE_LANE_N)
      |-> (~COLUMN_STROBE_LANE_N & ~REQ_BE) == 4'h0)
    else $error("idle lane cas");
  self_hold_a: assert property (
    REFRESH_ENABLE_BIT && REFRESH_MODE_SELECT && !ROW_STROBE_N
      && COLUMN_STROBE_LANE_N == 4'h0 |=> !REFRESH_MODE_SELECT
      || (!ROW_STROBE_N && COLUMN_STROBE_LANE_N == 4'h0))
    else $error("self refresh lost");
  release_quiet_a: assert property (
    BUS_RELEASED |-> &CHIP_SELECT_N && READ_STROBE_N && &WRITE_STROBE_LANE_N
      && ADDRESS_PHASE_STROBE_N && !DATA_OE)
    else $error("released bus driven");

  // ===
  // multiplexed space and timer
  addr_phase_len_a: assert property (
    $fell(ADDRESS_PHASE_STROBE_N) |=> !ADDRESS_PHASE_STROBE_N ##1
      !ADDRESS_PHASE_STROBE_N ##1 ADDRESS_PHASE_STROBE_N)
    else $error("address length");
  addr_phase_drv_a: assert property (
    !ADDRESS_PHASE_STROBE_N |-> DATA_OE && !CHIP_SELECT_N[3])
    else $error("address drive");
  match_clears_a: assert property (
    $rose(MATCH_FLAG) |-> REFRESH_COUNTER == 8'h00)
    else $error("match not cleared");
  stopped_count_a: assert property (
    COUNTER_CLOCK_SELECT == 3'h0 && !REFRESH_COUNTER_WR |=> $stable(REFRESH_COUNTER))
    else $error("stopped counter moved");

  // main scenarios reached
  mux_seen_c: cover property ($fell(ADDRESS_PHASE_STROBE_N));
  done_seen_c: cover property (REQ_DONE && REQ_ADDR[31:24] == 8'h01);
  self_seen_c: cover property (BUS_RELEASED && !ROW_STROBE_N);
endmodule : ebd_bus_ctrl_sva

bind ebd_bus_ctrl ebd_bus_ctrl_sva u_ebd_bus_ctrl_sva (.*);

// File: ebd_mem_model.sv
// far-side memory on the strobes
// assumes word index on address bits 5..2
`timescale 1ns/1ps
module ebd_mem_model (
  input wire logic CLOCK,
  READ_STROBE_N,
  READ_WRITE_DIRECTION,
  input wire logic [3:0] WRITE_STROBE_LANE_N,
  COLUMN_STROBE_LANE_N,
  STALL_CYCLES,
  input wire logic [21:0] ADDR_OUT,
  input wire logic [31:0] DATA_OUT,
  output logic [31:0] DATA_IN,
  output logic WAIT_N
);
  logic [31:0] mem [0:15];
  logic [31:0] last = 32'h0;
  logic [3:0] cnt = 4'h0;
  logic cas, act, rd, wr;
  // either protocol's strobe opens an access
  assign cas = !(&COLUMN_STROBE_LANE_N);
  assign rd = !READ_STROBE_N || (cas && READ_WRITE_DIRECTION);
  assign wr = !(&WRITE_STROBE_LANE_N) || (cas && !READ_WRITE_DIRECTION);
  assign act = rd || wr;
  // wait low from strobe start, so it leads any sample
  assign WAIT_N = !(act && cnt < STALL_CYCLES);
  // a released bus shows the inverse of the last value
  assign DATA_IN = rd ? mem[ADDR_OUT[5:2]] : ~last;
  // count strobe cycles and store written words
  always @(posedge CLOCK) begin
    cnt <= act ? cnt + 4'h1 : 4'h0;
    if (rd) last <= mem[ADDR_OUT[5:2]];
    if (wr) mem[ADDR_OUT[5:2]] <= DATA_OUT;
  end
endmodule : ebd_mem_model

// File: ebd_tb.sv
// self-checking bench of the bus controller
// assumes the checker is bound in
`timescale 1ns/1ps
module testbench;
  logic CLOCK, RESETN, CE, REQ_VALID, REQ_WRITE, REQ_DMA_SINGLE, PRECHARGE_WAIT;
  logic ROW_TO_COLUMN_DELAY, BURST_ENABLE_BIT, ROW_HOLD_MODE, MUX_IO_ENABLE;
  logic REFRESH_ENABLE_BIT, REFRESH_MODE_SELECT, REFRESH_COUNTER_WR, MATCH_FLAG_CLR;
  logic MATCH_INTERRUPT_ENABLE, EXT_GRANT, WAIT_N, REQ_BUSY, REQ_DONE, MATCH_FLAG;
  logic MATCH_IRQ, BUS_RELEASED, READ_STROBE_N, ROW_STROBE_N, READ_WRITE_DIRECTION;
  logic ADDRESS_PHASE_STROBE_N, DATA_OE;
  logic [1:0] ORD_WAITS, ROW_SHIFT, DRAM_WRITE_WAIT, DRAM_READ_WAIT, REFRESH_ROW_WIDTH;
  logic [2:0] COUNTER_CLOCK_SELECT;
  logic [3:0] REQ_BE, SELECT_EXTEND_FIELD, CHIP_SELECT_N, WRITE_STROBE_LANE_N;
  logic [3:0] COLUMN_STROBE_LANE_N, STALL_CYCLES, cas_seen;
  logic [7:0] REFRESH_COMPARE_VALUE, REFRESH_COUNTER_WDATA, REFRESH_COUNTER;
  logic [15:0] ah_seen;
  logic [21:0] ADDR_OUT, row_seen;
  logic [31:0] REQ_ADDR, REQ_WDATA, REQ_RDATA, DATA_OUT, DATA_IN;
  int n_mismatch = 0, n_checks = 0, cyc = 0, ras_w = 0, ras_last = 0, rd_seen = 0;

  ebd_bus_ctrl u_ebd_bus_ctrl (.*);
  ebd_mem_model u_ebd_mem_model (.*);

  // ===
  // clock, bus watch and hang guard
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // pin watch at the sampling edge
  always @(posedge CLOCK) begin
    if (!ROW_STROBE_N && ras_w == 0) row_seen <= ADDR_OUT;
    if (ROW_STROBE_N && ras_w != 0) ras_last <= ras_w;
    ras_w <= ROW_STROBE_N ? 0 : ras_w + 1;
    if (!(&COLUMN_STROBE_LANE_N)) cas_seen <= COLUMN_STROBE_LANE_N;
    if (!ADDRESS_PHASE_STROBE_N) ah_seen <= DATA_OUT[15:0];
    if (!READ_STROBE_N) rd_seen <= 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ===
  // shared tasks
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // stall counts only where external wait is honoured
  function automatic int lat(int base, int w, int s, int thr);
    return base + ((w >= thr && s > w) ? s : w);
  endfunction : lat

  // one access held until done; n is edges take to done
  task automatic acc(input logic [31:0] a, input logic wr, input logic [3:0] be,
    input logic [31:0] d, output int n);
    do @(negedge CLOCK); while (REQ_BUSY !== 1'b0);
    {REQ_VALID, REQ_ADDR, REQ_WRITE, REQ_BE, REQ_WDATA} = {1'b1, a, wr, be, d};
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
      #1;
    end while (REQ_DONE !== 1'b1 && n < 60);
    @(negedge CLOCK);
    REQ_VALID = 1'b0;
  endtask : acc

  // ===
  // scenarios
  task automatic t_ord();
    int w[5] = '{0, 0, 2, 2, 1};
    int s[5] = '{0, 4, 0, 4, 0};
    int n;
    for (int i = 0; i < 5; i++) begin
      ORD_WAITS = w[i][1:0];
      SELECT_EXTEND_FIELD = {3'h0, i == 4};
      STALL_CYCLES = s[i][3:0];
      acc(32'h40 + 4 * i, 1'b1, 4'hf, 32'h5a00_0000 + i, n);
      chk(n, (i == 4) + lat(3, w[i], s[i], 1), "ord wr len");
      acc(32'h40 + 4 * i, 1'b0, 4'hf, 32'h0, n);
      chk(n, (i == 4) + lat(3, w[i], s[i], 1), "ord rd len");
      chk(REQ_RDATA, 32'h5a00_0000 + i, "ord data");
    end
    acc(32'h60, 1'b1, 4'hf, 32'h1, n);
    chk({DATA_OE, CHIP_SELECT_N[0], WRITE_STROBE_LANE_N}, 6'h2f, "tail");
    $display("test ord done");
  endtask : t_ord

  task automatic t_dram();
    int p[4] = '{0, 1, 0, 0};
    int r[4] = '{0, 1, 0, 1};
    int w[4] = '{0, 2, 3, 1};
    int s[4] = '{0, 0, 5, 4};
    logic [31:0] a;
    logic [21:0] m;
    int n;
    for (int k = 0; k < 4; k++) begin
      a = 32'h01c3_5a40 + 4 * k;
      m = 22'((24'h1 << (15 - k)) - 24'h1);
      {ROW_SHIFT, PRECHARGE_WAIT, ROW_TO_COLUMN_DELAY} = {k[1:0], p[k][0], r[k][0]};
      {DRAM_WRITE_WAIT, DRAM_READ_WAIT, STALL_CYCLES} = {w[k][1:0], w[k][1:0], s[k][3:0]};
      acc(a, 1'b1, 4'hf, 32'hc0de_0000 + k, n);
      chk(n, lat(5 + p[k] + r[k], w[k], s[k], 2), "dram wr len");
      rd_seen = 0;
      acc(a, 1'b0, 4'h6, 32'h0, n);
      chk(n, lat(5 + p[k] + r[k], w[k], s[k], 2), "dram rd len");
      chk(row_seen, (a[21:0] & ~m) | (22'(a[23:0] >> (9 + k)) & m), "row");
      chk(REQ_RDATA[23:8], 16'hde00, "dram data");
      chk(cas_seen, 4'h9, "lanes");
      chk(rd_seen, 0, "no rd");
    end
    REQ_DMA_SINGLE = 1'b1;
    acc(32'h01c3_5a40, 1'b0, 4'hf, 32'h0, n);
    REQ_DMA_SINGLE = 1'b0;
    chk(rd_seen, 1, "dma rd");
    $display("test dram done");
  endtask : t_dram

  task automatic t_mux();
    int n;
    {MUX_IO_ENABLE, ORD_WAITS, STALL_CYCLES} = {1'b1, 2'h0, 4'h0};
    acc(32'h0c00_4123, 1'b0, 4'hf, 32'h0, n);
    chk(n, 6, "mux len");
    chk(ah_seen, 16'h4123, "wide");
    acc(32'h0c00_0177, 1'b0, 4'hf, 32'h0, n);
    chk(ah_seen[7:0], 8'h77, "narrow");
    MUX_IO_ENABLE = 1'b0;
    $display("test mux done");
  endtask : t_mux

  task automatic t_page();
    int n;
    {BURST_ENABLE_BIT, ROW_HOLD_MODE, DRAM_READ_WAIT, ROW_SHIFT} = 6'h30;
    acc(32'h01c3_5a40, 1'b0, 4'hf, 32'h0, n);
    acc(32'h0000_0040, 1'b0, 4'hf, 32'h0, n);
    chk(ROW_STROBE_N, 0, "row kept");
    acc(32'h01c3_5a44, 1'b0, 4'hf, 32'h0, n);
    chk(n < 5, 1, "page hit");
    {BURST_ENABLE_BIT, ROW_HOLD_MODE} = 2'h0;
    acc(32'h01c0_0040, 1'b0, 4'hf, 32'h0, n);
    $display("test page done");
  endtask : t_page

  task automatic t_refresh();
    int n;
    logic [7:0] hold;
    {REFRESH_ROW_WIDTH, REFRESH_COMPARE_VALUE, MATCH_INTERRUPT_ENABLE} = {2'h2, 8'h05, 1'b1};
    {REFRESH_ENABLE_BIT, REFRESH_COUNTER_WR, COUNTER_CLOCK_SELECT} = {2'h3, 3'h1};
    @(negedge CLOCK);
    REFRESH_COUNTER_WR = 1'b0;
    n = 0;
    while (MATCH_FLAG !== 1'b1 && n < 100) begin
      @(negedge CLOCK);
      n++;
    end
    chk(MATCH_FLAG, 1, "match flag");
    repeat (2) @(negedge CLOCK);
    chk(MATCH_IRQ, 1, "match irq");
    repeat (8) @(negedge CLOCK);
    chk(ras_last, 3, "ras width");
    MATCH_FLAG_CLR = 1'b1;
    @(negedge CLOCK);
    {MATCH_FLAG_CLR, COUNTER_CLOCK_SELECT, REFRESH_ENABLE_BIT} = 5'h0;
    repeat (2) @(negedge CLOCK);
    hold = REFRESH_COUNTER;
    chk({MATCH_FLAG, MATCH_IRQ}, 2'h0, "cleared");
    repeat (20) @(negedge CLOCK);
    chk(REFRESH_COUNTER, hold, "stopped");
    $display("test refresh done");
  endtask : t_refresh

  task automatic t_self();
    {REFRESH_ENABLE_BIT, REFRESH_MODE_SELECT} = 2'h3;
    repeat (10) @(negedge CLOCK);
    chk({ROW_STROBE_N, COLUMN_STROBE_LANE_N}, 5'h0, "self");
    EXT_GRANT = 1'b1;
    repeat (5) @(negedge CLOCK);
    chk({BUS_RELEASED, ROW_STROBE_N, COLUMN_STROBE_LANE_N, CHIP_SELECT_N}, 10'h20f,
      "released");
    {EXT_GRANT, REFRESH_ENABLE_BIT, REFRESH_MODE_SELECT} = 3'h0;
    repeat (10) @(negedge CLOCK);
    chk({BUS_RELEASED, ROW_STROBE_N}, 2'h1, "self left");
    $display("test self done");
  endtask : t_self

  // ===
  // verdict and main sequence
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  initial begin
    {RESETN, REQ_VALID, REQ_WRITE, REQ_DMA_SINGLE, PRECHARGE_WAIT, ROW_TO_COLUMN_DELAY} = '0;
    {BURST_ENABLE_BIT, ROW_HOLD_MODE, MUX_IO_ENABLE, REFRESH_ENABLE_BIT} = '0;
    {REFRESH_MODE_SELECT, REFRESH_COUNTER_WR, MATCH_FLAG_CLR, MATCH_INTERRUPT_ENABLE} = '0;
    {EXT_GRANT, ORD_WAITS, ROW_SHIFT, DRAM_WRITE_WAIT, DRAM_READ_WAIT} = '0;
    {REFRESH_ROW_WIDTH, COUNTER_CLOCK_SELECT, REQ_BE, SELECT_EXTEND_FIELD} = '0;
    {STALL_CYCLES, REFRESH_COMPARE_VALUE, REFRESH_COUNTER_WDATA, REQ_ADDR, REQ_WDATA} = '0;
    CE = 1'b1;
    repeat (20) @(posedge CLOCK);
    @(negedge CLOCK);
    RESETN = 1'b1;
    t_ord();
    t_dram();
    t_mux();
    t_page();
    t_refresh();
    t_self();
    test_done();
  end
endmodule : testbench
